/* logic/sspr_port.sv */
// Serial slave register port: protocol engine
`timescale 1ns/1ps
`include "sspr_cfg.svh"
module sspr_port (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic ss_n_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [15:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [31:0] reg_rdata_i,
    input wire logic [1:0] reg_width_i,
    input wire logic [7:0] config_reg_i,
    output logic cap_port_en_o,
    output logic spi_mode_o,
    output logic spi_lock_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    sspr_pkg::sspr_pins_t pins;
    sspr_pkg::sspr_pins_t lvl;
    sspr_pkg::sspr_pins_t rise;
    sspr_pkg::sspr_pins_t fall;

    assign pins.sclk = sclk_i;
    assign pins.mosi = mosi_i;
    assign pins.ss_n = ss_n_i;

    sspr_sync #(
        .W(3)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .pin_i(pins),
        .lvl_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    sspr_pkg::sspr_state_t state_r;
    sspr_pkg::sspr_state_t state_nxt;
    sspr_pkg::sspr_req_t req_r;
    sspr_pkg::sspr_req_t req_nxt;
    logic [31:0] rx_r;
    logic [31:0] rx_nxt;
    logic [31:0] tx_r;
    logic [31:0] tx_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] len_r;
    logic [5:0] len_nxt;
    logic rd_cmd_r;
    logic rd_cmd_nxt;
    logic burst_r;
    logic burst_nxt;
    logic miso_r;
    logic miso_nxt;
    logic oe_r;
    logic oe_nxt;
    logic [1:0] falls_r;
    logic mode_r;
    logic lock_r;
    logic lock_nxt;
    logic cap_r;

    ////////////////////////////////////////////////////////////////////////
    // Decoding
    wire sclk_up = rise.sclk;
    wire sclk_dn = fall.sclk;
    wire frame_end = rise.ss_n;
    wire frame_start = fall.ss_n;
    wire third_fall = frame_start & (falls_r == `SSPR_SEL_FALLS - 2'h1);
    wire mode_on = mode_r | third_fall;
    wire [31:0] rx_shift = {rx_r[30:0], lvl.mosi};
    wire [5:0] cnt_inc = cnt_r + 6'h01;
    wire [5:0] look_len = (reg_width_i == `SSPR_W32) ? `SSPR_LEN32 :
                          (reg_width_i == `SSPR_W16) ? `SSPR_LEN16 :
                          `SSPR_LEN8;
    wire [31:0] look_data = (reg_width_i == `SSPR_W32) ? reg_rdata_i :
                            (reg_width_i == `SSPR_W16) ?
                            {reg_rdata_i[15:0], 16'h0000} :
                            {reg_rdata_i[7:0], 24'h000000};
    wire in_burst = (req_r.addr >= `SSPR_BURST_LO) &
                    (req_r.addr <= `SSPR_BURST_HI);
    wire next_in = req_r.addr < `SSPR_BURST_HI;
    wire [15:0] addr_inc = req_r.addr + 16'h0001;
    wire wr_cfg2 = req_r.addr == `SSPR_CFG2_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        req_nxt.wr = 1'b0;
        req_nxt.rd = 1'b0;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        cnt_nxt = cnt_r;
        len_nxt = len_r;
        rd_cmd_nxt = rd_cmd_r;
        burst_nxt = burst_r;
        miso_nxt = miso_r;
        oe_nxt = oe_r;
        lock_nxt = lock_r;
        if (lvl.ss_n) begin
            state_nxt = sspr_pkg::ST_IDLE;
            oe_nxt = 1'b0;
            miso_nxt = 1'b0;
        end else begin
            case (state_r)
                sspr_pkg::ST_IDLE: begin
                    if (frame_start & mode_on) begin
                        state_nxt = sspr_pkg::ST_CMD;
                        cnt_nxt = 6'h00;
                    end
                end
                sspr_pkg::ST_CMD: begin
                    if (sclk_up) begin
                        rx_nxt = rx_shift;
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == `SSPR_CMD_BITS) begin
                            rd_cmd_nxt = lvl.mosi;
                            cnt_nxt = 6'h00;
                            state_nxt = sspr_pkg::ST_ADDR;
                        end
                    end
                end
                sspr_pkg::ST_ADDR: begin
                    if (sclk_up) begin
                        rx_nxt = rx_shift;
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == `SSPR_ADDR_BITS) begin
                            req_nxt.addr = rx_shift[15:0];
                            req_nxt.rd = rd_cmd_r;
                            cnt_nxt = 6'h00;
                            state_nxt = sspr_pkg::ST_LOOK;
                        end
                    end
                end
                sspr_pkg::ST_LOOK: begin
                    len_nxt = look_len;
                    tx_nxt = look_data;
                    cnt_nxt = 6'h00;
                    burst_nxt = rd_cmd_r & in_burst &
                                (reg_width_i == `SSPR_W32);
                    state_nxt = rd_cmd_r ? sspr_pkg::ST_RDATA :
                                sspr_pkg::ST_WDATA;
                end
                sspr_pkg::ST_WDATA: begin
                    if (sclk_up) begin
                        rx_nxt = rx_shift;
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == len_r) begin
                            req_nxt.wdata = rx_shift;
                            req_nxt.wr = 1'b1;
                            lock_nxt = lock_r | wr_cfg2;
                            state_nxt = sspr_pkg::ST_DONE;
                        end
                    end
                end
                sspr_pkg::ST_RDATA: begin
                    if (sclk_dn) begin
                        miso_nxt = tx_r[31];
                        oe_nxt = 1'b1;
                        tx_nxt = {tx_r[30:0], 1'b0};
                        cnt_nxt = cnt_inc;
                        if (cnt_inc == len_r) begin
                            if (burst_r & next_in) begin
                                req_nxt.addr = addr_inc;
                                req_nxt.rd = 1'b1;
                                state_nxt = sspr_pkg::ST_LOOK;
                            end else begin
                                state_nxt = sspr_pkg::ST_DONE;
                            end
                        end
                    end
                end
                sspr_pkg::ST_DONE: begin
                    if (sclk_dn) begin
                        oe_nxt = 1'b0;
                        miso_nxt = 1'b0;
                    end
                end
                default: begin
                    state_nxt = sspr_pkg::ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= sspr_pkg::ST_IDLE;
            req_r <= '0;
            rx_r <= 32'h00000000;
            tx_r <= 32'h00000000;
            cnt_r <= 6'h00;
            len_r <= `SSPR_LEN8;
            rd_cmd_r <= 1'b0;
            burst_r <= 1'b0;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
            lock_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            cnt_r <= cnt_nxt;
            len_r <= len_nxt;
            rd_cmd_r <= rd_cmd_nxt;
            burst_r <= burst_nxt;
            miso_r <= miso_nxt;
            oe_r <= oe_nxt;
            lock_r <= lock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port selection and capture port gating
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            falls_r <= 2'h0;
            mode_r <= 1'b0;
            cap_r <= 1'b0;
        end else if (ce_i) begin
            if (frame_start & ~mode_r) begin
                falls_r <= falls_r + 2'h1;
            end
            mode_r <= mode_on;
            cap_r <= config_reg_i[`SSPR_CAP_EN_BIT] & ~mode_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign miso_o = miso_r;
    assign miso_oe_o = oe_r;
    assign reg_addr_o = req_r.addr;
    assign reg_wdata_o = req_r.wdata;
    assign reg_wr_o = req_r.wr;
    assign reg_rd_o = req_r.rd;
    assign cap_port_en_o = cap_r;
    assign spi_mode_o = mode_r;
    assign spi_lock_o = lock_r;
endmodule : sspr_port

/* logic/sspr_cfg.svh */
// Constants for the serial register port
// Operation
// - Port is slave only on clock, data in, data out, select; never drives clock.
// - Serial clock at most 2.5 MHz; logic works at any lower rate.
// - Master changes data in on falling edge; device captures on rising edge.
// - Device changes data out on falling edge; master captures on rising edge.
// - Command, address and data all travel most significant bit first.
// - Data out stays released whenever no read data is being shifted.
// - Select rising mid-transfer abandons it and releases outputs at once.
// - First byte is command; bit 0 low means write; upper bits ignored.
// - Write is command, 16-bit address, then 32/16/8 data, no idle clocks.
// - First read bit driven on falling edge right after last address bit.
// - Burst only for 32-bit registers 0xE50C to 0xE51B, same command as read.
// - Burst continues with next address after each register until select rises or register 0xE51B has been sent.
// - Capture port enable bit 6 has no effect while serial port is active.
// - Three select falling edges after reset select this port until reset.
// - Any write to secondary config register locks this port as host port.
`ifndef SSPR_CFG_SVH
`define SSPR_CFG_SVH
`define SSPR_CMD_BITS 6'h08
`define SSPR_ADDR_BITS 6'h10
`define SSPR_LEN8 6'h08
`define SSPR_LEN16 6'h10
`define SSPR_LEN32 6'h20
`define SSPR_W8 2'h0
`define SSPR_W16 2'h1
`define SSPR_W32 2'h2
`define SSPR_BURST_LO 16'he50c
`define SSPR_BURST_HI 16'he51b
`define SSPR_CFG2_ADDR 16'hec01
`define SSPR_CAP_EN_BIT 6
`define SSPR_SEL_FALLS 2'h3
`define SSPR_SCLK_MAX_KHZ 2500
`define SSPR_CLK_KHZ 50000
`endif

/* logic/sspr_pkg.sv */
// Types for the serial register port
package sspr_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ADDR = 3'b010,
        ST_LOOK = 3'b011,
        ST_WDATA = 3'b100,
        ST_RDATA = 3'b101,
        ST_DONE = 3'b110
    } sspr_state_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic ss_n;
    } sspr_pins_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sspr_req_t;
endpackage : sspr_pkg

/* logic/sspr_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module sspr_sync #(
    parameter int W = 3
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                s1_r[g] <= 1'b1;
                s2_r[g] <= 1'b1;
                s3_r[g] <= 1'b1;
            end else if (ce_i) begin
                s1_r[g] <= pin_i[g];
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
            end
        end
        assign rise_o[g] = s2_r[g] & ~s3_r[g];
        assign fall_o[g] = ~s2_r[g] & s3_r[g];
    end
    assign lvl_o = s2_r;
endmodule : sspr_sync

/* verif/sspr_port_assertions.sv */
// Concurrent checks on the serial register port
`timescale 1ns/1ps
module sspr_port_assertions (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ss_n_i,
    input wire logic [7:0] config_reg_i,
    input wire logic miso_oe_o,
    input wire logic reg_wr_o,
    input wire logic reg_rd_o,
    input wire logic cap_port_en_o,
    input wire logic spi_mode_o,
    input wire logic spi_lock_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    AST_REL_IDLE: assert property (ss_n_i [*6] |-> !miso_oe_o)
        else $error("data out driven while deselected");
    AST_WR_ONE: assert property (reg_wr_o |=> !reg_wr_o)
        else $error("write strobe too long");
    AST_RD_ONE: assert property (reg_rd_o |=> !reg_rd_o)
        else $error("read strobe too long");
    AST_MODE_HOLD: assert property (spi_mode_o |=> spi_mode_o)
        else $error("port selection lost");
    AST_LOCK_HOLD: assert property (
        spi_lock_o |=> $stable(spi_lock_o))
        else $error("port lock lost");
    AST_LOCK_MODE: assert property (
        $rose(spi_lock_o) |-> spi_mode_o)
        else $error("lock without serial mode");
    AST_CAP_OFF: assert property (spi_mode_o |=> !cap_port_en_o)
        else $error("capture enable active in serial mode");
    AST_CAP_FOLLOW: assert property (
        !spi_mode_o && !$past(spi_mode_o)
        |-> cap_port_en_o == $past(config_reg_i[6]))
        else $error("capture enable not following config");
    AST_IDLE_PRE: assert property (
        !spi_mode_o |-> !miso_oe_o && !reg_wr_o)
        else $error("frame served before selection");
    AST_WR_SEL: assert property (reg_wr_o |-> !ss_n_i)
        else $error("write strobe after deselect");
    cover property (reg_wr_o);
    cover property (reg_rd_o);
    cover property ($rose(spi_lock_o));
    cover property ($rose(miso_oe_o));
endmodule : sspr_port_assertions
bind sspr_port sspr_port_assertions u_chk (.clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i), .ss_n_i(ss_n_i), .config_reg_i(config_reg_i),
    .miso_oe_o(miso_oe_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
    .cap_port_en_o(cap_port_en_o), .spi_mode_o(spi_mode_o),
    .spi_lock_o(spi_lock_o));

/* verif/sspr_master.sv */
// Serial master model driving the port pins
`timescale 1ns/1ps
module sspr_master (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic ss_n_o
);
    localparam int HALF = 10;
    initial begin
        sclk_o = 1'b1;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end
    task automatic xfer(input logic [7:0] c, input logic [15:0] a,
        input int nd, input logic [31:0] wd, input int cut,
        output logic [63:0] rd);
        logic [87:0] f;
        if (c[7:1] == 7'h38) c[7] = ~c[7];
        f = {c, a, 64'(wd) << (64 - nd)};
        rd = 64'h0;
        @(negedge clk_i);
        ss_n_o = 1'b0;
        repeat (HALF) @(negedge clk_i);
        for (int i = 0; i < 24 + nd && i != cut; i++) begin
            sclk_o = 1'b0;
            mosi_o = f[87 - i];
            repeat (HALF) @(negedge clk_i);
            sclk_o = 1'b1;
            if (i >= 24) rd = {rd[62:0], miso_i};
            repeat (HALF) @(negedge clk_i);
        end
        ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (2 * HALF) @(negedge clk_i);
    endtask : xfer
endmodule : sspr_master

/* verif/sspr_port_bench.sv */
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module sspr_port_bench;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic sclk, mosi, ss_n, miso_o, miso_oe_o, tog = 1'b0;
    logic [15:0] reg_addr_o;
    logic [31:0] reg_wdata_o, reg_rdata_i, a32, d32, exp_d;
    logic [1:0] reg_width_i;
    logic [7:0] cfg = 8'h00;
    logic ce = 1'b1;
    logic reg_wr_o, reg_rd_o, cap_port_en_o, spi_mode_o, spi_lock_o;
    logic [15:0] exp_a;
    logic [63:0] rd;
    int n_errors = 0, n_compared = 0, n_wr = 0, n_rd = 0, k, w0, wb, r0;
    integer seed = 32'h0f52b817;
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) tog <= ~tog;
    wire miso_w = miso_oe_o ? miso_o : tog;
    function automatic logic [1:0] wid(input logic [15:0] a);
        return (a >= 16'he50c && a <= 16'he51b) ? 2'h2 : a[1:0];
    endfunction : wid
    function automatic int nbits(input logic [1:0] w);
        return (w == 2'h1) ? 16 : (w == 2'h2) ? 32 : 8;
    endfunction : nbits
    function automatic logic [31:0] rval(input logic [15:0] a);
        return {a ^ 16'h5a3c, ~a};
    endfunction : rval
    function automatic logic [63:0] msk(input int n);
        return (n >= 64) ? ~64'h0 : (64'h1 << n) - 64'h1;
    endfunction : msk
    assign reg_width_i = wid(reg_addr_o);
    assign reg_rdata_i = rval(reg_addr_o);
    sspr_port dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce),
        .sclk_i(sclk), .mosi_i(mosi), .ss_n_i(ss_n), .miso_o(miso_o),
        .miso_oe_o(miso_oe_o), .reg_addr_o(reg_addr_o),
        .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rd_o(reg_rd_o),
        .reg_rdata_i(reg_rdata_i), .reg_width_i(reg_width_i),
        .config_reg_i(cfg), .cap_port_en_o(cap_port_en_o),
        .spi_mode_o(spi_mode_o), .spi_lock_o(spi_lock_o));
    sspr_master m (.clk_i(clk_sys_i), .miso_i(miso_w), .sclk_o(sclk),
        .mosi_o(mosi), .ss_n_o(ss_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic summarize;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic wr(input logic [15:0] a, input logic [31:0] d, int cut);
        exp_a = a;
        exp_d = d;
        m.xfer(8'($random(seed)) & 8'hfe, a, nbits(wid(a)), d, cut,
            rd);
    endtask : wr
    task automatic rdchk(input logic [15:0] a, int n, logic [63:0] e);
        r0 = n_rd;
        m.xfer(8'($random(seed)) | 8'h01, a, n, 32'h0, 999, rd);
        chk(rd & msk(n), e & msk(n));
        chk(n_rd - r0, (n > 32) ? 2 : 1);
    endtask : rdchk
    always @(negedge clk_sys_i) begin
        if (reg_rd_o === 1'b1) begin
            n_rd++;
        end
        if (reg_wr_o === 1'b1) begin
            n_wr++;
            chk(reg_addr_o, exp_a);
            wb = nbits(wid(exp_a));
            chk(reg_wdata_o & msk(wb), exp_d & msk(wb));
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk_sys_i);
        arst_n_i = 1'b1;
        chk(spi_mode_o, 1'b0);
        cfg = 8'($random(seed)) | 8'h40;
        repeat (3) @(negedge clk_sys_i);
        chk(cap_port_en_o, 1'b1);
        for (k = 0; k < 3; k++) begin
            wr(16'hebff, 32'h5a, 999);
        end
        chk(n_wr, 1);
        chk(spi_mode_o, 1'b1);
        chk(cap_port_en_o, 1'b0);
        for (k = 0; k < 8; k++) begin
            a32 = $random(seed);
            d32 = $random(seed);
            a32[15] = 1'b0;
            a32[1:0] = 2'(k);
            wr(a32[15:0], d32, 999);
            chk(n_wr, k + 2);
            rdchk(a32[15:0], nbits(wid(a32[15:0])), rval(a32[15:0]));
        end
        w0 = n_wr;
        ce = 1'b0;
        wr(16'h0203, 32'h77, 999);
        ce = 1'b1;
        chk(n_wr, w0);
        wr(16'h0102, 32'h12345678, 34);
        chk(n_wr, w0);
        rdchk(16'he51a, 64, {rval(16'he51a), rval(16'he51b)});
        wr(16'hec01, 32'h1, 30);
        chk(spi_lock_o, 1'b0);
        wr(16'hec01, 32'h1, 999);
        chk(spi_lock_o, 1'b1);
        summarize();
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        n_errors++;
        summarize();
    end
endmodule : sspr_port_bench
